/* ext_bus_defs.svh */
// Timing, reset and encoding constants for the external bus interface
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// Space codes of a core request
`define SPACE_PROG 2'h0
`define SPACE_DATA 2'h1
`define SPACE_IO 2'h2
`define SPACE_GLOBAL 2'h3
// Boot address for either boot memory
`define BOOT_ADDR 16'h0000
// Wait-state count width and reset value
`define WAIT_W 3
`define WAIT_RESET 3'h7
// Visibility mode after reset
`define VIS_RESET 1'b1

`endif

/* ext_bus_pkg.sv */
// Types shared by the external bus interface
package ext_bus_pkg;
    // Bus cycle states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } bus_state_t;

    // Core request bundle
    typedef struct packed {
        logic [1:0] space;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    // Pin strobe bundle, all active low except rw
    typedef struct packed {
        logic io_sel_n;
        logic data_sel_n;
        logic prog_sel_n;
        logic strobe_n;
        logic gdr_n;
        logic rd_n;
        logic we_n;
        logic rw;
    } bus_pins_t;
endpackage : ext_bus_pkg

/* external_bus_interface.sv */
// External memory and I/O bus interface of the controller core
// How it works
// - Only the accessed space select goes low
// - Space selects float in reset, powerdown, float
// - Write strobe low on every external write
// - Write strobe floats while float input low
// - Read strobe low through reads; floats likewise
// - Direction high except writes; floats likewise
// - Access strobe low each offchip cycle
// - Global request low on global data access
// - Global request floats in powerdown, float; driven high in reset
// - Ready low adds one cycle, resampled
// - Ready sampled only with nonzero wait states
// - Visibility clock follows core clock output
// - Visibility enable low when driving data
// - Visibility mode on after reset
// - Disabled interface flags illegal address
// - Boot memory select sampled at reset
`include "ext_bus_defs.svh"

module external_bus_interface (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire ext_bus_pkg::bus_req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic illegal_addr_o,
    input wire logic [`WAIT_W-1:0] wait_states_i,
    input wire logic vis_mode_set_i,
    input wire logic vis_mode_value_i,
    input wire logic power_down_i,
    input wire logic emulator_float_n_i,
    input wire logic ext_interface_enable_i,
    input wire logic boot_memory_select_i,
    input wire logic ready_i,
    input wire logic core_clock_output_i,
    input wire logic [15:0] vis_data_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic [15:0] addr_o,
    output ext_bus_pkg::bus_pins_t pins_o,
    output logic pins_oe_o,
    output logic selects_oe_o,
    output logic visibility_clock_o,
    output logic visibility_bus_drive_n_o,
    output logic boot_external_o,
    output logic [15:0] boot_addr_o,
    output logic bus_visibility_mode_o
);
    // Pin input synchronisers, first stage read only by second
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic ready_s;
    logic float_n_s;
    logic enable_s;
    // Bus cycle state
    ext_bus_pkg::bus_state_t state_reg;
    ext_bus_pkg::bus_req_t cur_reg;
    logic [`WAIT_W-1:0] wait_cnt_reg;
    logic [`WAIT_W-1:0] wait_prog_reg;
    ext_bus_pkg::bus_pins_t pins_reg;
    logic [15:0] rdata_reg;
    logic done_reg;
    logic illegal_reg;
    logic vis_reg;
    logic boot_reg;
    logic boot_taken_reg;
    logic boot_meta_reg; // Strap first stage, read only by second
    logic boot_sync_reg; // Strap second stage
    logic in_reset_reg;
    logic active;

    // Active low one-hot select for a space
    function automatic logic [2:0] space_sel_n(input logic [1:0] space);
        logic [2:0] s;
        s = 3'h7;
        case (space)
            `SPACE_PROG: s = 3'b110;
            `SPACE_DATA: s = 3'b101;
            `SPACE_GLOBAL: s = 3'b101;
            `SPACE_IO: s = 3'b011;
            default: s = 3'h7;
        endcase
        return s;
    endfunction : space_sel_n

    // Two-flop sync of ready, float and enable pins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_reg <= 3'h7;
            pin_sync_reg <= 3'h7;
        end else begin
            pin_meta_reg <= {ready_i, emulator_float_n_i, ext_interface_enable_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign ready_s = pin_sync_reg[2];
    assign float_n_s = pin_sync_reg[1];
    assign enable_s = pin_sync_reg[0];

    // High through reset until the first edge after release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_reset_reg <= 1'b1;
        end else begin
            in_reset_reg <= 1'b0;
        end
    end

    // Strap sync left unreset so it tracks the pin through reset
    // Limitation: strap must be steady two edges before release
    always_ff @(posedge clk_i) begin
        boot_meta_reg <= boot_memory_select_i;
        boot_sync_reg <= boot_meta_reg;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_reg <= 1'b0;
            boot_taken_reg <= 1'b0;
        end else if (!boot_taken_reg) begin
            // Caught on the first edge after release, held after
            boot_reg <= boot_sync_reg;
            boot_taken_reg <= 1'b1;
        end
    end
    assign boot_external_o = boot_reg;
    assign boot_addr_o = `BOOT_ADDR;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vis_reg <= `VIS_RESET;
        end else if (vis_mode_set_i) begin
            vis_reg <= vis_mode_value_i;
        end
    end
    assign bus_visibility_mode_o = vis_reg;

    // Request taken only when idle; power down blocks new cycles
    assign req_ready_o = (state_reg == ext_bus_pkg::ST_IDLE) && !power_down_i;

    // Bus cycle sequencer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ext_bus_pkg::ST_IDLE;
            cur_reg <= '0;
            wait_cnt_reg <= '0;
            wait_prog_reg <= '0;
        end else begin
            case (state_reg)
                ext_bus_pkg::ST_IDLE: begin
                    if (req_valid_i && req_ready_o && enable_s) begin
                        cur_reg <= req_i;
                        wait_cnt_reg <= wait_states_i;
                        wait_prog_reg <= wait_states_i;
                        state_reg <= ext_bus_pkg::ST_WAIT;
                    end
                end
                ext_bus_pkg::ST_WAIT: begin
                    if (wait_cnt_reg != '0) begin
                        wait_cnt_reg <= wait_cnt_reg - `WAIT_W'(1);
                    // ready ignored with zero wait states
                    // ready low holds one more cycle
                    end else if (wait_prog_reg == '0 || ready_s) begin
                        state_reg <= ext_bus_pkg::ST_DONE;
                    end
                end
                // one idle cycle with strobes high
                ext_bus_pkg::ST_DONE: state_reg <= ext_bus_pkg::ST_IDLE;
                default: state_reg <= ext_bus_pkg::ST_IDLE;
            endcase
        end
    end
    assign active = (state_reg == ext_bus_pkg::ST_WAIT);

    // Strobe pin levels registered from state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_reg <= '1;
        end else if (state_reg == ext_bus_pkg::ST_IDLE && req_valid_i && req_ready_o
                     && enable_s) begin
            // only the accessed space select goes low
            {pins_reg.io_sel_n, pins_reg.data_sel_n, pins_reg.prog_sel_n} <=
                space_sel_n(req_i.space);
            // access strobe low for the cycle
            pins_reg.strobe_n <= 1'b0;
            pins_reg.gdr_n <= (req_i.space != `SPACE_GLOBAL);
            pins_reg.rd_n <= req_i.write;
            pins_reg.we_n <= !req_i.write;
            pins_reg.rw <= !req_i.write;
        end else if (active && (wait_cnt_reg == '0)
                     && (wait_prog_reg == '0 || ready_s)) begin
            // release all strobes at cycle end
            pins_reg <= '1;
        end
    end

    // Address, write data and read capture
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_o <= '0;
            data_o <= '0;
            rdata_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg == ext_bus_pkg::ST_IDLE && req_valid_i && req_ready_o) begin
                addr_o <= req_i.addr;
                data_o <= req_i.wdata;
            end else if (!active && vis_reg) begin
                // Visibility shows internal bus traffic
                data_o <= vis_data_i;
            end
            if (active && wait_cnt_reg == '0 && (wait_prog_reg == '0 || ready_s)) begin
                done_reg <= 1'b1;
                if (!cur_reg.write) begin
                    rdata_reg <= data_i;
                end
            end
        end
    end
    assign done_o = done_reg;
    assign rdata_o = rdata_reg;

    // illegal address pulse when interface disabled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            illegal_reg <= 1'b0;
        end else begin
            illegal_reg <= req_valid_i && req_ready_o && !enable_s;
        end
    end
    assign illegal_addr_o = illegal_reg;

    assign pins_o = pins_reg;
    // strobes float while float input low
    // access strobe floats in power down
    assign pins_oe_o = float_n_s && !power_down_i;
    assign selects_oe_o = float_n_s && !power_down_i && !in_reset_reg;
    // data bus driven during visibility or write
    assign data_oe_o = (vis_reg && !active) || (active && cur_reg.write);
    assign visibility_bus_drive_n_o = !(vis_reg && !active);
    // visibility clock follows core clock output
    assign visibility_clock_o = vis_reg ? core_clock_output_i : 1'b0;

    chk_sel_one_hot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $countones({pins_o.io_sel_n, pins_o.data_sel_n, pins_o.prog_sel_n}) >= 2)
        else $error("more than one space select low");
    chk_sel_idle_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pins_o.strobe_n |-> pins_o.io_sel_n && pins_o.data_sel_n && pins_o.prog_sel_n)
        else $error("space select low outside a bus cycle");
    chk_we_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pins_o.we_n |-> cur_reg.write && !pins_o.strobe_n)
        else $error("write strobe without write");
    chk_float_oe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !float_n_s |-> !pins_oe_o && !selects_oe_o)
        else $error("strobes driven while float low");
    chk_rd_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pins_o.rd_n |-> !cur_reg.write && pins_o.we_n)
        else $error("read strobe on write");
    chk_rw_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pins_o.rw == pins_o.we_n)
        else $error("direction disagrees with write strobe");
    chk_gdr_space: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pins_o.gdr_n |-> !pins_o.data_sel_n)
        else $error("global request without data select");
    chk_ready_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        active && wait_cnt_reg == '0 && wait_prog_reg != '0 && !ready_s
        |=> active && !pins_o.strobe_n)
        else $error("cycle ended with ready low");
    chk_zero_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        active && wait_prog_reg == '0 |=> state_reg == ext_bus_pkg::ST_DONE ##1 pins_o.strobe_n)
        else $error("zero wait cycle stalled");
    chk_idle_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ext_bus_pkg::ST_DONE |-> pins_o == '1)
        else $error("strobes low between cycles");
    chk_vis_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !visibility_bus_drive_n_o |-> data_oe_o)
        else $error("visibility enable without drive");
    // access strobe low exactly in cycle
    chk_strobe_active: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        active == !pins_o.strobe_n)
        else $error("access strobe out of step with bus cycle");
    chk_illegal_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        illegal_addr_o |-> pins_o.strobe_n && state_reg == ext_bus_pkg::ST_IDLE)
        else $error("bus cycle started while interface disabled");
endmodule : external_bus_interface

/* ext_mem_model.sv */
// Far-side memory and slow-device ready model
module ext_mem_model (
    input wire logic clk_i,
    input wire ext_bus_pkg::bus_pins_t pins_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [3:0] stall_i,
    output logic [15:0] rdata_o,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16]; // Word store on low address bits
    logic [3:0] cnt = 4'h0; // Strobe-low cycles so far
    // Write lands while strobe and write enable are low
    always @(posedge clk_i) begin
        if (!pins_i.strobe_n && !pins_i.we_n) begin
            mem[addr_i[3:0]] <= wdata_i;
        end
        cnt <= pins_i.strobe_n ? 4'h0 : cnt + 4'h1;
    end
    assign ready_o = (stall_i == 4'h0) || (!pins_i.strobe_n && cnt >= stall_i);
    // Released bus falls to its pull-down level, so a late sample fails
    assign rdata_o = !pins_i.rd_n ? mem[addr_i[3:0]] : 16'h0000;
endmodule : ext_mem_model

/* external_bus_interface_tb_top.sv */
// Self-checking bench for the external bus interface
`include "ext_bus_defs.svh"
module external_bus_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
        $display("BAD %s exp %h got %h", nm, e, g); end end
    logic clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0;
    ext_bus_pkg::bus_req_t req_i = '0;
    logic req_ready_o, done_o, illegal_addr_o, data_oe_o, pins_oe_o, selects_oe_o, ready_i;
    logic visibility_clock_o, visibility_bus_drive_n_o, boot_external_o, bus_visibility_mode_o;
    logic [15:0] rdata_o, data_o, addr_o, boot_addr_o, data_i, mdat, madr;
    logic mdoe; // Data drive enable seen mid-cycle
    logic boot_memory_select_i = 1'b1; // Boot strap pin
    logic [`WAIT_W-1:0] wait_states_i = '0;
    logic vis_mode_set_i = 1'b0, vis_mode_value_i = 1'b0, power_down_i = 1'b0;
    logic emulator_float_n_i = 1'b1, ext_interface_enable_i = 1'b1, core_clock_output_i = 1'b0;
    logic [3:0] stall = 4'h0; // Ready hold-off of the far side
    ext_bus_pkg::bus_pins_t pins_o, mid; // Pins, and pins seen mid-cycle
    int miscompares = 0, n_compared = 0, lat;
    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    external_bus_interface dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .illegal_addr_o(illegal_addr_o), .wait_states_i(wait_states_i),
        .vis_mode_set_i(vis_mode_set_i), .vis_mode_value_i(vis_mode_value_i),
        .power_down_i(power_down_i), .emulator_float_n_i(emulator_float_n_i),
        .ext_interface_enable_i(ext_interface_enable_i),
        .boot_memory_select_i(boot_memory_select_i),
        .ready_i(ready_i), .core_clock_output_i(core_clock_output_i), .vis_data_i(16'h3c5a),
        .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .addr_o(addr_o),
        .pins_o(pins_o), .pins_oe_o(pins_oe_o), .selects_oe_o(selects_oe_o),
        .visibility_clock_o(visibility_clock_o),
        .visibility_bus_drive_n_o(visibility_bus_drive_n_o), .boot_external_o(boot_external_o),
        .boot_addr_o(boot_addr_o), .bus_visibility_mode_o(bus_visibility_mode_o));
    ext_mem_model far_end (.clk_i(clk_i), .pins_i(pins_o), .addr_i(addr_o), .wdata_i(data_o),
        .stall_i(stall), .rdata_o(data_i), .ready_o(ready_i));
    // Pins expected in the middle of a cycle
    function automatic ext_bus_pkg::bus_pins_t exp_pins(input logic [1:0] sp, input logic wr);
        exp_pins = '{io_sel_n: sp != 2'h2, data_sel_n: !sp[0], prog_sel_n: sp != 2'h0,
            strobe_n: 1'b0, gdr_n: sp != 2'h3, rd_n: wr, we_n: !wr, rw: !wr};
    endfunction : exp_pins
    // One bus cycle; latency counted in cycles from the edge that raises the request
    task automatic access(input logic [1:0] sp, input logic wr, input logic [15:0] a, d);
        req_i = '{space: sp, write: wr, addr: a, wdata: d};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        mid = pins_o;
        mdat = data_o;
        madr = addr_o;
        mdoe = data_oe_o;
        lat = 1;
        while (done_o !== 1'b1 && lat < 40) begin
            @(negedge clk_i);
            lat++;
        end
        if (lat >= 40) begin
            miscompares++;
            conclude();
        end
        `CHK("pins_end", 8'hff, pins_o)
        @(negedge clk_i);
    endtask : access
    // Reset levels and boot strap
    task automatic t_reset();
        repeat (8) @(negedge clk_i);
        `CHK("rst_pins", 8'hff, pins_o)
        `CHK("rst_sel_oe", 1'b0, selects_oe_o)
        `CHK("rst_vis", 1'b1, bus_visibility_mode_o)
        `CHK("rst_doe", 1'b1, data_oe_o)
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("boot", 1'b1, boot_external_o)
        `CHK("boot_addr", 16'h0000, boot_addr_o)
        $display("END reset");
    endtask : t_reset
    // ready held low yet zero waits ignore it
    task automatic t_spaces();
        stall = 4'hf;
        for (int i = 0; i < 8; i++) begin
            access(i[1:0], i < 4, {14'h0, i[1:0]}, {14'h3054, i[1:0]});
            `CHK("lat0", 2, lat)
            `CHK("sel", exp_pins(i[1:0], i < 4), mid)
            `CHK("addr", {14'h0, i[1:0]}, madr)
            `CHK("doe", i < 4, mdoe)
            if (i < 4) `CHK("wdata", {14'h3054, i[1:0]}, mdat)
            else `CHK("rdata", {14'h3054, i[1:0]}, rdata_o)
        end
        $display("END spaces");
    endtask : t_spaces
    task automatic t_waits();
        stall = 4'h0;
        wait_states_i = 3'h3;
        access(2'h1, 1'b0, 16'h0001, 16'h0);
        `CHK("lat3", 5, lat)
        wait_states_i = 3'h1;
        stall = 4'h6;
        access(2'h2, 1'b0, 16'h0002, 16'h0);
        `CHK("lat_rdy", 1'b1, lat inside {[8:12]})
        `CHK("rd_wait", 16'hc152, rdata_o)
        stall = 4'h0;
        $display("END waits");
    endtask : t_waits
    // Float input and power down release the pins
    task automatic t_float();
        emulator_float_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("oe_float", 1'b0, pins_oe_o)
        `CHK("sel_float", 1'b0, selects_oe_o)
        emulator_float_n_i = 1'b1;
        power_down_i = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("rdy_pd", 1'b0, req_ready_o)
        `CHK("oe_pd", 1'b0, pins_oe_o)
        `CHK("sel_pd", 1'b0, selects_oe_o)
        power_down_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("oe_on", 1'b1, pins_oe_o)
        `CHK("sel_on", 1'b1, selects_oe_o)
        $display("END float");
    endtask : t_float
    task automatic t_disabled();
        int n;
        n = 0;
        ext_interface_enable_i = 1'b0;
        repeat (3) @(negedge clk_i);
        req_i = '{space: 2'h0, write: 1'b0, addr: 16'h0, wdata: 16'h0};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        while (illegal_addr_o !== 1'b1 && n < 3) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 3) begin
            miscompares++;
            conclude();
        end
        `CHK("illegal", 1'b1, illegal_addr_o)
        `CHK("no_cycle", 8'hff, pins_o)
        ext_interface_enable_i = 1'b1;
        repeat (4) @(negedge clk_i);
        $display("END disabled");
    endtask : t_disabled
    // Visibility mode off, then on again
    task automatic t_vis();
        core_clock_output_i = 1'b1;
        for (int v = 0; v < 2; v++) begin
            vis_mode_set_i = 1'b1;
            vis_mode_value_i = v[0];
            @(negedge clk_i);
            vis_mode_set_i = 1'b0;
            repeat (2) @(negedge clk_i);
            `CHK("vis_mode", v[0], bus_visibility_mode_o)
            `CHK("visibility_clock", v[0], visibility_clock_o)
            `CHK("vis_drv", !v[0], visibility_bus_drive_n_o)
        end
        `CHK("vis_data", 16'h3c5a, data_o)
        core_clock_output_i = 1'b0;
        #1;
        `CHK("visibility_clock_lo", 1'b0, visibility_clock_o)
        $display("END vis");
    endtask : t_vis
    // Second reset mid-run with the strap low and visibility off
    task automatic t_boot();
        vis_mode_set_i = 1'b1;
        vis_mode_value_i = 1'b0;
        @(negedge clk_i);
        vis_mode_set_i = 1'b0;
        boot_memory_select_i = 1'b0;
        rst_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("rst2_pins", 8'hff, pins_o)
        `CHK("rst2_sel_oe", 1'b0, selects_oe_o)
        `CHK("rst2_vis", 1'b1, bus_visibility_mode_o)
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("boot_int", 1'b0, boot_external_o)
        `CHK("boot_int_addr", 16'h0000, boot_addr_o)
        $display("END boot");
    endtask : t_boot
    // Counts and verdict
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        t_reset();
        t_spaces();
        t_waits();
        t_float();
        t_disabled();
        t_vis();
        t_boot();
        conclude();
    end
endmodule : external_bus_interface_tb_top
